/* rtl/dacpin_map.svh */
// Purpose : constants for the converter control pin block
// Assumes : 50 MHz system clock
// Notes   : times are kept in their printed unit, counts derived
`ifndef DACPIN_MAP_SVH
`define DACPIN_MAP_SVH
`define DACPIN_CLK_MHZ        50
`define DACPIN_RST_QUIET_US   100
`define DACPIN_RST_QUIET_CYC  (`DACPIN_RST_QUIET_US * `DACPIN_CLK_MHZ)
`define DACPIN_FRAME_BITS     24
`define DACPIN_CMD_POS        23
`define DACPIN_WR_CMD         1'b0
`define DACPIN_ADDR_HI        22
`define DACPIN_ADDR_LO        16
`define DACPIN_ADDR_DATA      7'h01
`define DACPIN_ADDR_GCFG      7'h02
`define DACPIN_ADDR_SWRST     7'h03
`define DACPIN_SWRST_KEY      16'ha5a5
`define DACPIN_COUPLE_BIT     0
`define DACPIN_DATA_RESET     16'h0000
`define DACPIN_GCFG_RESET     16'h0000
`endif

/* rtl/dacpin_pkg.sv */
// Purpose : shared types for the converter control pin block
// Assumes : nothing
// Notes   : frame layout is command, address, data
package dacpin_pkg;
  typedef struct packed {
    logic       read;
    logic [6:0] addr;
    logic [15:0] data;
  } dacpin_frame_t;

  typedef struct packed {
    logic        clk;
    logic        frame_n;
    logic        din;
    logic        load_n;
  } dacpin_pins_t;
endpackage

/* rtl/dacpin_sync.sv */
// Purpose : two-flop synchroniser for the host pins
// Assumes : pins idle high
// Notes   : first stage is read only by the second stage
`timescale 1ns/100ps
module dacpin_sync (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  // pins
  input  wire dacpin_pkg::dacpin_pins_t i_pins,
  output dacpin_pkg::dacpin_pins_t      o_pins
);
  dacpin_pkg::dacpin_pins_t stage1;
  dacpin_pkg::dacpin_pins_t stage2;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      stage1 <= '1;
      stage2 <= '1;
    end else begin
      stage1 <= i_pins;
      stage2 <= stage1;
    end
  end

  assign o_pins = stage2;
endmodule

/* rtl/dacpin_ctrl.sv */
// Purpose : serial frame capture, load strobe and coupling control
// Assumes : host pins asynchronous, sampled at 50 MHz
// Notes   : serial clock up to about 12 MHz is resolved by sampling
// Summary of operation
// R1 - low reset pin fully resets device
// R2 - host waits 100 us after reset
// R3 - load strobe moves pending data out
// R4 - host keeps strobe off near frame end
// R5 - modem coupling off until enable bit
// R6 - readback shifts out; clock max 15 MHz
// R7 - frame low; sample data on falling clock
// R8 - write clock up to 50 MHz; the 50 MHz sampling here resolves only about 12 MHz
`timescale 1ns/100ps
`include "dacpin_map.svh"
module dacpin_ctrl (
  // clock and reset (pin reset, active low)
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // serial port pins
  input  wire logic        i_serial_clk,
  input  wire logic        i_frame_n,
  input  wire logic        i_serial_din,
  output logic             o_serial_dout,
  // load strobe pin
  input  wire logic        i_load_output_strobe_n,
  // converter side
  output logic [15:0]      o_output_code,
  output logic             o_modem_coupling_input_connect,
  output logic             o_busy
);
  localparam int RST_QUIET = `DACPIN_RST_QUIET_CYC;

  //////////////////////////////////////////////////////////////////////////////
  dacpin_pkg::dacpin_pins_t pins_s;
  dacpin_pkg::dacpin_pins_t pins_d;
  dacpin_pkg::dacpin_frame_t frame;
  dacpin_pkg::dacpin_pins_t  pins_raw;

  // all four host pins cross together so their relative order survives
  assign pins_raw = '{clk: i_serial_clk, frame_n: i_frame_n, din: i_serial_din,
                      load_n: i_load_output_strobe_n};

  dacpin_sync dacpin_sync_i (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_pins    (pins_raw),
    .o_pins    (pins_s)
  );

  logic        sclk_fall;
  logic        sclk_rise;
  logic        frame_rise;
  logic        frame_fall;
  assign sclk_fall  = pins_d.clk & ~pins_s.clk;
  assign sclk_rise  = ~pins_d.clk & pins_s.clk;
  assign frame_rise = ~pins_d.frame_n & pins_s.frame_n;
  assign frame_fall = pins_d.frame_n & ~pins_s.frame_n;

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  logic [23:0] shift_in;
  logic [4:0]  bit_cnt;
  logic [15:0] pending;
  logic [15:0] out_code;
  logic [15:0] gcfg;
  logic [15:0] shift_out;
  logic        rd_armed;
  logic        dout;
  logic [12:0] quiet_cnt;
  logic        soft_rst;

  logic [23:0] next_shift_in;
  logic [4:0]  next_bit_cnt;
  logic [15:0] next_pending;
  logic [15:0] next_out_code;
  logic [15:0] next_gcfg;
  logic [15:0] next_shift_out;
  logic        next_rd_armed;
  logic        next_dout;
  logic [12:0] next_quiet_cnt;
  logic        next_soft_rst;

  function automatic logic [15:0] reg_value(input logic [6:0] addr,
                                            input logic [15:0] p,
                                            input logic [15:0] g);
    case (addr)
      `DACPIN_ADDR_DATA: reg_value = p;
      `DACPIN_ADDR_GCFG: reg_value = g;
      default:           reg_value = 16'h0000;
    endcase
  endfunction

  always_comb begin
    next_shift_in  = shift_in;
    next_bit_cnt   = bit_cnt;
    next_pending   = pending;
    next_out_code  = out_code;
    next_gcfg      = gcfg;
    next_shift_out = shift_out;
    next_rd_armed  = rd_armed;
    next_dout      = dout;
    next_soft_rst  = 1'b0;
    next_quiet_cnt = (quiet_cnt != 13'h0000) ? quiet_cnt - 13'h0001 : quiet_cnt;
    frame          = shift_in;
    if (frame_fall) begin
      next_bit_cnt = 5'h00;
      if (rd_armed) begin
        next_dout = shift_out[15];
      end
    end
    // R7 falling-edge capture
    // a fall in the frame's first cycle must count from zero, not the old count
    if (!pins_s.frame_n && sclk_fall && next_bit_cnt < 5'(`DACPIN_FRAME_BITS)) begin
      next_shift_in = {shift_in[22:0], pins_s.din};
      next_bit_cnt  = next_bit_cnt + 5'h01;
    end
    // R6 readback shift out
    if (!pins_s.frame_n && rd_armed && sclk_rise) begin
      next_shift_out = {shift_out[14:0], 1'b0};
      next_dout      = shift_out[14];
    end
    if (frame_rise) begin
      next_dout     = 1'b0;
      next_rd_armed = 1'b0;
      if (bit_cnt == 5'(`DACPIN_FRAME_BITS)) begin
        if (frame.read) begin
          next_shift_out = reg_value(frame.addr, pending, gcfg);
          next_rd_armed  = 1'b1;
        end else begin
          case (frame.addr)
            `DACPIN_ADDR_DATA:  next_pending = frame.data;
            // R5 coupling enable bit
            `DACPIN_ADDR_GCFG:  next_gcfg = frame.data;
            `DACPIN_ADDR_SWRST: next_soft_rst = (frame.data == `DACPIN_SWRST_KEY);
            default: ;
          endcase
        end
      end
    end
    // R3 strobe loads output
    if (!pins_s.load_n) begin
      next_out_code = pending;
    end
  end

  always_ff @(posedge i_clock) begin
    // R1 full reset
    if (!i_reset_n || soft_rst) begin
      shift_in  <= 24'h000000;
      bit_cnt   <= 5'h00;
      pending   <= `DACPIN_DATA_RESET;
      out_code  <= `DACPIN_DATA_RESET;
      gcfg      <= `DACPIN_GCFG_RESET;
      shift_out <= 16'h0000;
      rd_armed  <= 1'b0;
      dout      <= 1'b0;
      quiet_cnt <= 13'(RST_QUIET);
      soft_rst  <= 1'b0;
      pins_d    <= '1;
    end else begin
      shift_in  <= next_shift_in;
      bit_cnt   <= next_bit_cnt;
      pending   <= next_pending;
      out_code  <= next_out_code;
      gcfg      <= next_gcfg;
      shift_out <= next_shift_out;
      rd_armed  <= next_rd_armed;
      dout      <= next_dout;
      quiet_cnt <= next_quiet_cnt;
      soft_rst  <= next_soft_rst;
      pins_d    <= pins_s;
    end
  end

  // R2 quiet time indicator; host must not send while busy
  assign o_busy                         = (quiet_cnt != 13'h0000);
  assign o_serial_dout                  = dout;
  assign o_output_code                  = out_code;
  assign o_modem_coupling_input_connect = gcfg[`DACPIN_COUPLE_BIT];

  //////////////////////////////////////////////////////////////////////////////
  coupling_reset_a: assert property (@(posedge i_clock) // R5
    !i_reset_n |=> !o_modem_coupling_input_connect)
    else $error("coupling not off after reset");
  output_reset_a: assert property (@(posedge i_clock) // R1
    !i_reset_n |=> o_output_code == 16'h0000 && !o_serial_dout)
    else $error("output not cleared by reset");
  load_moves_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R3
    !pins_s.load_n && !soft_rst |=> o_output_code == $past(pending))
    else $error("load did not move pending data");
  hold_no_load_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R3
    pins_s.load_n && !soft_rst |=> $stable(o_output_code))
    else $error("output changed without load");
  capture_fall_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R7
    !pins_s.frame_n && sclk_fall && bit_cnt < 5'(`DACPIN_FRAME_BITS) && !soft_rst
      |=> shift_in[0] == $past(pins_s.din))
    else $error("data not captured on falling clock");
  no_capture_idle_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R7
    pins_s.frame_n && !frame_fall && !soft_rst |=> $stable(shift_in))
    else $error("data captured outside frame");
  quiet_time_a: assert property (@(posedge i_clock) // R2
    !i_reset_n ##1 i_reset_n [*8] |-> o_busy)
    else $error("quiet indicator dropped early");
  readback_shift_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R6
    rd_armed && !pins_s.frame_n && sclk_rise && !frame_rise && !soft_rst
      |=> o_serial_dout == $past(shift_out[14]))
    else $error("readback bit wrong");
  soft_reset_busy_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R2
    soft_rst |=> o_busy && o_output_code == 16'h0000 && !o_modem_coupling_input_connect)
    else $error("software reset did not restart quiet time");
  short_frame_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R7
    frame_rise && bit_cnt != 5'(`DACPIN_FRAME_BITS) && !soft_rst
      |=> $stable(pending) && $stable(gcfg) && !rd_armed)
    else $error("frame with wrong bit count acted on");
  couple_write_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R5
    frame_rise && bit_cnt == 5'(`DACPIN_FRAME_BITS)
      && shift_in[`DACPIN_CMD_POS] == `DACPIN_WR_CMD
      && shift_in[`DACPIN_ADDR_HI:`DACPIN_ADDR_LO] == `DACPIN_ADDR_GCFG && !soft_rst
      |=> o_modem_coupling_input_connect == $past(shift_in[`DACPIN_COUPLE_BIT]))
    else $error("coupling bit not taken from config write");
  dout_idle_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R6
    pins_s.frame_n |=> !o_serial_dout)
    else $error("readback line driven outside frame");
endmodule

/* bench/dacpin_host_model.sv */
// Purpose : host side of the serial port and load strobe
// Assumes : pins idle high; all changes at falling system clock
// Notes   : 160 ns serial clock, only inside frames
`timescale 1ns/100ps
module dacpin_host_model (
  // clock
  input  wire logic i_clock,
  // pins
  input  wire logic i_serial_dout,
  output logic      o_serial_clk,
  output logic      o_frame_n,
  output logic      o_serial_din,
  output logic      o_load_n
);
  initial begin
    o_serial_clk = 1'b1;
    o_frame_n    = 1'b1;
    o_serial_din = 1'b1;
    o_load_n     = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  ////////////////////////////////////////////////////////////////
  // data set before fall; 6.25 MHz
  task automatic xfer(input logic [23:0] f, input int nbits, output logic [15:0] rd);
    rd        = 16'h0000;
    o_frame_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_serial_din = f[23-i];
      tick(5);
      if (i < 16) rd = {rd[14:0], i_serial_dout};
      o_serial_clk = 1'b0;
      tick(3);
      o_serial_clk = 1'b1;
    end
    tick(5);
    o_frame_n    = 1'b1;
    // released data line must not keep its last value
    o_serial_din = ~o_serial_din;
    // strobe quiet 1.6 us after frame end
    tick(80);
  endtask
  // strobe then 600 ns gap before any frame end
  task automatic load_pulse();
    o_load_n = 1'b0;
    tick(6);
    o_load_n = 1'b1;
    tick(30);
  endtask
endmodule

/* bench/dacpin_ctrl_tb_top.sv */
// Purpose : self-checking bench for the control pin block
// Assumes : host model drives all serial input pins and the load strobe
// Notes   : seed 9, random data codes
`timescale 1ns/100ps
`include "dacpin_map.svh"
module dacpin_ctrl_tb_top;
  logic        i_clock = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        sclk, frame_n, din, dout, load_n, couple, busy;
  logic [15:0] code, d, rd, prev;
  int          errors = 0;
  int          total_checks = 0;
  always #10 i_clock = ~i_clock;
  dacpin_ctrl dacpin_ctrl_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_serial_clk(sclk), .i_frame_n(frame_n), .i_serial_din(din),
    .o_serial_dout(dout), .i_load_output_strobe_n(load_n), .o_output_code(code),
    .o_modem_coupling_input_connect(couple), .o_busy(busy));
  dacpin_host_model dacpin_host_model_i (.i_clock(i_clock), .i_serial_dout(dout),
    .o_serial_clk(sclk), .o_frame_n(frame_n), .o_serial_din(din), .o_load_n(load_n));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [23:0] frm(input logic r, input logic [6:0] a, input logic [15:0] v);
    dacpin_pkg::dacpin_frame_t f;
    f = '{read: r, addr: a, data: v};
    return f;
  endfunction
  // no command until quiet time is over
  // used: cycles of quiet time already spent before the call
  task automatic wait_quiet(input int used);
    int n;
    for (n = 0; n < 6000 && busy !== 1'b0; n++) @(negedge i_clock);
    check("quiet_len", {15'h0, (n + used) >= `DACPIN_RST_QUIET_CYC - 10 &&
          (n + used) <= `DACPIN_RST_QUIET_CYC + 10}, 16'h0001);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    dacpin_host_model_i.xfer(frm(1'b0, a, v), 24, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge i_clock);
    errors++;
    close_out();
  end
  initial begin
    void'($urandom(9));
    prev = `DACPIN_DATA_RESET;
    repeat (12) @(negedge i_clock);
    check("code_rst", code, 16'h0000);
    check("couple_rst", {15'h0, couple}, 16'h0000);
    i_reset_n = 1'b1;
    wait_quiet(0);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 16'hffff : 16'($urandom);
      wr(`DACPIN_ADDR_DATA, d);
      check("code_hold", code, prev);
      dacpin_host_model_i.load_pulse();
      check("code_load", code, d);
      prev = d;
      dacpin_host_model_i.xfer(frm(1'b1, `DACPIN_ADDR_DATA, 16'h0000), 24, rd);
      dacpin_host_model_i.xfer(frm(1'b1, `DACPIN_ADDR_DATA, 16'h0000), 24, rd);
      check("readback", rd, d);
    end
    dacpin_host_model_i.xfer(frm(1'b0, `DACPIN_ADDR_DATA, ~prev), 23, rd);
    dacpin_host_model_i.load_pulse();
    check("short_frame", code, prev);
    for (int k = 0; k < 3; k++) begin
      wr(`DACPIN_ADDR_GCFG, {15'h0, k != 1});
      check("couple", {15'h0, couple}, {15'h0, k != 1});
    end
    dacpin_host_model_i.xfer(frm(1'b1, `DACPIN_ADDR_GCFG, 16'h0000), 24, rd);
    dacpin_host_model_i.xfer(frm(1'b1, 7'h7f, 16'h0000), 24, rd);
    check("gcfg_read", rd, 16'h0001);
    dacpin_host_model_i.xfer(frm(1'b1, `DACPIN_ADDR_GCFG, 16'h0000), 24, rd);
    check("unmapped_read", rd, 16'h0000);
    wr(`DACPIN_ADDR_SWRST, `DACPIN_SWRST_KEY);
    check("sw_busy", {15'h0, busy}, 16'h0001);
    // the host model already idled 80 cycles after the frame end
    wait_quiet(80);
    check("sw_code", code, 16'h0000);
    check("sw_couple", {15'h0, couple}, 16'h0000);
    wr(`DACPIN_ADDR_GCFG, 16'h0001);
    wr(`DACPIN_ADDR_DATA, 16'h5a3c);
    dacpin_host_model_i.load_pulse();
    check("pre_code", code, 16'h5a3c);
    check("pre_couple", {15'h0, couple}, 16'h0001);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clock);
    check("pin_code", code, 16'h0000);
    check("pin_couple", {15'h0, couple}, 16'h0000);
    i_reset_n = 1'b1;
    wait_quiet(0);
    close_out();
  end
endmodule
